/* swk_pkg.sv */
package swk_pkg;
   localparam int SWK_AW = 12;
   localparam int SWK_NPINS = 12;
   localparam logic [SWK_AW-1:0] SWK_OFS_PMT = 12'h014;
   localparam logic [SWK_AW-1:0] SWK_OFS_CFG0 = 12'h018;
   localparam logic [SWK_AW-1:0] SWK_OFS_CFG1 = 12'h01C;
   localparam logic [SWK_AW-1:0] SWK_OFS_PWAKE = 12'h020;
   localparam logic [SWK_AW-1:0] SWK_OFS_WUC1 = 12'h024;
   localparam logic [SWK_AW-1:0] SWK_OFS_RFC = 12'h028;
   localparam logic [SWK_AW-1:0] SWK_OFS_WSRC = 12'h02C;
   // Power management control fields
   localparam int PMT_WS0 = 0;
   localparam int PMT_WS1 = 1;
   localparam int PMT_LAN_EN = 2;
   localparam int PMT_PHY_EN = 3;
   localparam int PMT_SLP_LSB = 4;
   localparam int PMT_SUSP = 8;
   // Pin config: cfg0 holds pins 7..0, cfg1 pins 11..8
   localparam int CFG0_NPINS = 8;
   localparam int CFG1_NPINS = 4;
   localparam int PWAKE_POL_LSB = 16;
   // Wake control/status 1 fields
   localparam int WUC_EXACT = 0;
   localparam int WUC_BCAST = 1;
   localparam int WUC_FPASS = 2;
   localparam int WUC_STORE = 3;
   // Receive filter control fields
   localparam int RFC_PASS = 4;
   // Wake source fields
   localparam int WSRC_LAN = 16;
   localparam int WSRC_LINK = 17;
   localparam int WSRC_GOOD = 18;
   localparam logic [31:0] SWK_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      SLP_A = 2'b00,
      SLP_B = 2'b01,
      SLP_C = 2'b10,
      SLP_D = 2'b11
   } swk_sleep_t;

   typedef enum logic {
      PS_NORMAL = 1'b0,
      PS_SUSP = 1'b1
   } swk_state_t;

   typedef struct packed {
      logic done;
      logic crc_ok;
      logic filt_pass;
      logic da_exact;
      logic bcast;
   } swk_rxfrm_t;
endpackage

/* swk_wake.sv */
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module swk_wake
   import swk_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [SWK_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic usb_suspend,
   input wire logic [SWK_NPINS-1:0] pin_in,
   input wire logic mac_wake_evt,
   input wire logic phy_irq,
   input wire swk_rxfrm_t rx_frame,
   output logic remote_wakeup,
   output logic suspended,
   output swk_sleep_t sleep_state,
   output logic rx_store,
   output logic rx_wake_flag
);
   // ----------------------------------------
   // Bus access
   // ----------------------------------------
   logic pready_reg, pslverr_reg, acc, wr, setup, mapped;
   logic [31:0] prdata_reg, rd_next;

   assign setup = psel && !penable && !pready_reg;
   assign acc = psel && penable && pready_reg;
   assign wr = acc && pwrite;

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic [1:0] wstat_reg;
   logic lan_en_reg, phy_en_reg, exact_en_reg, broadcast_wake_enable_reg, fpass_en_reg, store_wake_reg, always_pass_wake_frame_reg;
   swk_sleep_t slp_sel_reg, slp_cur_reg;
   logic [SWK_NPINS-1:0] pin_fen_reg, pin_wen_reg, pin_pol_reg, src_pin_reg;
   logic src_lan_reg, src_link_reg, src_good_reg;
   swk_state_t state_reg;
   logic usb_susp_q_reg, remote_wakeup_reg, rx_store_reg, rx_wake_flag_reg;

   // ----------------------------------------
   // Wake detection
   // ----------------------------------------
   logic [SWK_NPINS-1:0] pin_hit;
   logic lan_evt, lan_ok, w_pin, w_lan, w_phy, w_good, good_frm, wake_now, frm_trig, in_susp;

   genvar gi;
   generate
      for (gi = 0; gi < SWK_NPINS; gi++)
      begin : g_pin
         assign pin_hit[gi] = pin_fen_reg[gi] && pin_wen_reg[gi]
                              && (pin_in[gi] == pin_pol_reg[gi]);
      end
   endgenerate

   assign in_susp = (state_reg == PS_SUSP);
   assign lan_evt = mac_wake_evt || (rx_frame.done && rx_frame.crc_ok
                    && ((exact_en_reg && rx_frame.da_exact)
                    || (broadcast_wake_enable_reg && rx_frame.bcast)));
   assign good_frm = rx_frame.done && rx_frame.crc_ok && rx_frame.filt_pass;
   assign w_pin = |pin_hit;
   assign lan_ok = lan_en_reg && (slp_cur_reg == SLP_A || slp_cur_reg == SLP_D);
   assign w_lan = wstat_reg[1] && lan_ok;
   assign w_phy = wstat_reg[0] && phy_en_reg
                  && (slp_cur_reg == SLP_A || slp_cur_reg == SLP_B);
   assign w_good = good_frm && fpass_en_reg && !lan_en_reg
                   && (slp_cur_reg == SLP_D);
   assign wake_now = in_susp && (w_pin || w_lan || w_phy || w_good);
   // LAN trigger frame ends a cycle before its wake
   assign frm_trig = in_susp && rx_frame.done
                     && (w_good || (lan_ok && lan_evt));

   // ----------------------------------------
   // Power management control
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lan_en_reg <= 1'b0;
         phy_en_reg <= 1'b0;
         slp_sel_reg <= SLP_A;
      end
      else if (wr && paddr == SWK_OFS_PMT)
      begin
         lan_en_reg <= pwdata[PMT_LAN_EN];
         phy_en_reg <= pwdata[PMT_PHY_EN];
         slp_sel_reg <= swk_sleep_t'(pwdata[PMT_SLP_LSB +: 2]);
      end
   end

   // Status bits: set wins over write-one-clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wstat_reg <= 2'b00;
      else
      begin
         wstat_reg[1] <= lan_evt || (wstat_reg[1]
                         && !(wr && paddr == SWK_OFS_PMT && pwdata[PMT_WS1]));
         wstat_reg[0] <= phy_irq || (wstat_reg[0]
                         && !(wr && paddr == SWK_OFS_PMT && pwdata[PMT_WS0]));
      end
   end

   // ----------------------------------------
   // Pin and filter configuration
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_fen_reg <= '0;
         pin_wen_reg <= '0;
         pin_pol_reg <= '0;
         exact_en_reg <= 1'b0;
         broadcast_wake_enable_reg <= 1'b0;
         fpass_en_reg <= 1'b0;
         store_wake_reg <= 1'b0;
         always_pass_wake_frame_reg <= 1'b0;
      end
      else if (wr)
      begin
         unique case (paddr)
            SWK_OFS_CFG0: pin_fen_reg[CFG0_NPINS-1:0] <= pwdata[CFG0_NPINS-1:0];
            SWK_OFS_CFG1: pin_fen_reg[SWK_NPINS-1:CFG0_NPINS] <= pwdata[CFG1_NPINS-1:0];
            SWK_OFS_PWAKE:
            begin
               pin_wen_reg <= pwdata[SWK_NPINS-1:0];
               pin_pol_reg <= pwdata[PWAKE_POL_LSB +: SWK_NPINS];
            end
            SWK_OFS_WUC1:
            begin
               exact_en_reg <= pwdata[WUC_EXACT];
               broadcast_wake_enable_reg <= pwdata[WUC_BCAST];
               fpass_en_reg <= pwdata[WUC_FPASS];
               store_wake_reg <= pwdata[WUC_STORE];
            end
            SWK_OFS_RFC: always_pass_wake_frame_reg <= pwdata[RFC_PASS];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Suspend state machine
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= PS_NORMAL;
         slp_cur_reg <= SLP_A;
         usb_susp_q_reg <= 1'b0;
         remote_wakeup_reg <= 1'b0;
      end
      else
      begin
         usb_susp_q_reg <= usb_suspend;
         remote_wakeup_reg <= wake_now;
         unique case (state_reg)
            PS_NORMAL:
               if (usb_suspend && !usb_susp_q_reg)
               begin
                  state_reg <= PS_SUSP;
                  slp_cur_reg <= slp_sel_reg;
               end
            PS_SUSP:
               if (wake_now || !usb_suspend)
                  state_reg <= PS_NORMAL;
         endcase
      end
   end

   // ----------------------------------------
   // Wake source flags
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         src_pin_reg <= '0;
         src_lan_reg <= 1'b0;
         src_link_reg <= 1'b0;
         src_good_reg <= 1'b0;
      end
      else
      begin
         src_pin_reg <= (pin_hit & {SWK_NPINS{wake_now}}) | (src_pin_reg
                        & ~({SWK_NPINS{wr && paddr == SWK_OFS_WSRC}}
                        & pwdata[SWK_NPINS-1:0]));
         src_lan_reg <= (wake_now && w_lan) || (src_lan_reg
                        && !(wr && paddr == SWK_OFS_WSRC && pwdata[WSRC_LAN]));
         src_link_reg <= (wake_now && w_phy) || (src_link_reg
                         && !(wr && paddr == SWK_OFS_WSRC && pwdata[WSRC_LINK]));
         src_good_reg <= (wake_now && w_good) || (src_good_reg
                         && !(wr && paddr == SWK_OFS_WSRC && pwdata[WSRC_GOOD]));
      end
   end

   // ----------------------------------------
   // Receive store control
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_store_reg <= 1'b0;
         rx_wake_flag_reg <= 1'b0;
      end
      else if (in_susp)
      begin
         rx_store_reg <= frm_trig && store_wake_reg && rx_frame.crc_ok
                         && (rx_frame.filt_pass || always_pass_wake_frame_reg);
         rx_wake_flag_reg <= frm_trig && store_wake_reg && rx_frame.crc_ok
                             && (rx_frame.filt_pass || always_pass_wake_frame_reg);
      end
      else
      begin
         rx_store_reg <= good_frm;
         rx_wake_flag_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Read data and answer
   // ----------------------------------------
   always_comb
   begin
      rd_next = SWK_ZERO;
      mapped = 1'b1;
      unique case (paddr)
         SWK_OFS_PMT:
         begin
            rd_next[PMT_WS1:PMT_WS0] = wstat_reg;
            rd_next[PMT_LAN_EN] = lan_en_reg;
            rd_next[PMT_PHY_EN] = phy_en_reg;
            rd_next[PMT_SLP_LSB +: 2] = slp_sel_reg;
            rd_next[PMT_SUSP] = in_susp;
         end
         SWK_OFS_CFG0: rd_next[CFG0_NPINS-1:0] = pin_fen_reg[CFG0_NPINS-1:0];
         SWK_OFS_CFG1: rd_next[CFG1_NPINS-1:0] = pin_fen_reg[SWK_NPINS-1:CFG0_NPINS];
         SWK_OFS_PWAKE:
         begin
            rd_next[SWK_NPINS-1:0] = pin_wen_reg;
            rd_next[PWAKE_POL_LSB +: SWK_NPINS] = pin_pol_reg;
         end
         SWK_OFS_WUC1:
         begin
            rd_next[WUC_EXACT] = exact_en_reg;
            rd_next[WUC_BCAST] = broadcast_wake_enable_reg;
            rd_next[WUC_FPASS] = fpass_en_reg;
            rd_next[WUC_STORE] = store_wake_reg;
         end
         SWK_OFS_RFC: rd_next[RFC_PASS] = always_pass_wake_frame_reg;
         SWK_OFS_WSRC:
         begin
            rd_next[SWK_NPINS-1:0] = src_pin_reg;
            rd_next[WSRC_LAN] = src_lan_reg;
            rd_next[WSRC_LINK] = src_link_reg;
            rd_next[WSRC_GOOD] = src_good_reg;
         end
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg <= 1'b0;
         prdata_reg <= SWK_ZERO;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         pready_reg <= setup;
         prdata_reg <= setup ? rd_next : SWK_ZERO;
         pslverr_reg <= setup && !mapped;
      end
   end

   assign pready = pready_reg;
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;
   assign remote_wakeup = remote_wakeup_reg;
   assign suspended = (state_reg == PS_SUSP);
   assign sleep_state = slp_cur_reg;
   assign rx_store = rx_store_reg;
   assign rx_wake_flag = rx_wake_flag_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_pin_wake_flag: assert property (in_susp && w_pin |=> state_reg == PS_NORMAL
      && remote_wakeup && ((src_pin_reg & $past(pin_hit)) == $past(pin_hit)))
      else $error("pin wake not taken");
   a_lan_pending: assert property (in_susp && w_lan |=> remote_wakeup && src_lan_reg)
      else $error("pending lan status did not wake");
   a_ws1_hold: assert property (mac_wake_evt |=> wstat_reg[1])
      else $error("lan status dropped under mac event");
   a_ws0_hold: assert property (phy_irq |=> wstat_reg[0])
      else $error("phy status dropped under phy irq");
   a_link_src: assert property (in_susp && w_phy |=> src_link_reg && !in_susp)
      else $error("link wake not recorded");
   a_bad_frame: assert property (rx_store |-> $past(rx_frame.done && rx_frame.crc_ok))
      else $error("corrupt frame stored");
   a_normal_store: assert property (!in_susp && good_frm |=> rx_store && !rx_wake_flag)
      else $error("good frame not stored");
   a_bypass_store: assert property (frm_trig && store_wake_reg && always_pass_wake_frame_reg
      && rx_frame.crc_ok |=> rx_store && rx_wake_flag)
      else $error("wake frame not passed");
   a_sleep_d: assert property (!in_susp && usb_suspend && !usb_susp_q_reg
      && slp_sel_reg == SLP_D |=> in_susp && sleep_state == SLP_D)
      else $error("sleep d not entered");
   a_src_sticky: assert property (src_good_reg && !(wr && paddr == SWK_OFS_WSRC)
      |=> src_good_reg)
      else $error("source flag lost");

   c_pin_wake: cover property (in_susp ##1 remote_wakeup && |src_pin_reg);
   c_lan_wake: cover property (in_susp && w_lan ##1 src_lan_reg);
   c_good_store: cover property (in_susp && w_good ##1 rx_wake_flag);
endmodule

/* swk_host_model.sv */
`timescale 1ns/10ps
module swk_host_model
   import swk_pkg::*;
(
   input wire logic pclk,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [SWK_AW-1:0] paddr,
   output logic [31:0] pwdata,
   output logic usb_suspend
);
   logic hung;

   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = SWK_ZERO;
      usb_suspend = 1'b0;
      hung = 1'b0;
   end

   // ----------------------------------------
   // APB transfer, held until pready or for at most 16 access cycles
   // ----------------------------------------
   task automatic xfer(input logic wr, input logic [SWK_AW-1:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (pready !== 1'b1)
         hung = 1'b1;
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // ----------------------------------------
   // Suspend entry and host resume
   // ----------------------------------------
   // MAC paths and offloads assumed already set up
   task automatic arm(input logic [31:0] pmt);
      logic [31:0] q;
      logic err;
      xfer(1'b1, SWK_OFS_PMT, pmt, q, err);
      @(posedge pclk);
      usb_suspend <= 1'b1;
   endtask

   task automatic resume();
      @(posedge pclk);
      usb_suspend <= 1'b0;
   endtask
endmodule

/* test_swk_wake.sv */
`timescale 1ns/10ps
module test_swk_wake
   import swk_pkg::*;
   ;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, usb_suspend;
   logic [SWK_AW-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [SWK_NPINS-1:0] pin_in = '0;
   logic mac_wake_evt = 1'b0;
   logic phy_irq = 1'b0;
   swk_rxfrm_t rx_frame = '0;
   logic remote_wakeup, suspended, rx_store, rx_wake_flag;
   swk_sleep_t sleep_state;
   int failures = 0;
   int cmp_count = 0;

   always #25 pclk = ~pclk;

   swk_wake dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                 .pslverr, .usb_suspend, .pin_in, .mac_wake_evt, .phy_irq, .rx_frame,
                 .remote_wakeup, .suspended, .sleep_state, .rx_store, .rx_wake_flag);

   swk_host_model host (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr,
                        .pwdata, .usb_suspend);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [SWK_AW-1:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic exp_err);
      logic [31:0] q;
      logic er;
      host.xfer(w, a, d, q, er);
      if (host.hung === 1'b1)
      begin
         failures++;
         wrap_up();
      end
      if (!w)
      begin
         chk(q, exp);
         chk({31'h0, er}, {31'h0, exp_err});
      end
   endtask

   task automatic wr(input logic [SWK_AW-1:0] a, input logic [31:0] d);
      bus(1'b1, a, d, SWK_ZERO, 1'b0);
   endtask

   task automatic rd(input logic [SWK_AW-1:0] a, input logic [31:0] exp, input logic exp_err);
      bus(1'b0, a, SWK_ZERO, exp, exp_err);
   endtask

   task automatic susp(input logic [31:0] pmt, input swk_sleep_t exp);
      host.arm(pmt);
      @(posedge pclk);
      #1;
      chk({31'h0, suspended}, 32'h1);
      chk({30'h0, sleep_state}, {30'h0, exp});
   endtask

   task automatic wait_wake();
      int n;
      for (n = 0; n < 8; n++)
      begin
         if (remote_wakeup === 1'b1)
            break;
         @(posedge pclk);
         #1;
      end
      chk({31'h0, remote_wakeup}, 32'h1);
      chk({31'h0, suspended}, 32'h0);
      if (remote_wakeup !== 1'b1)
         wrap_up();
      host.resume();
   endtask

   task automatic send(input swk_rxfrm_t f, input logic ev, input logic [1:0] exp);
      @(posedge pclk);
      rx_frame <= f;
      mac_wake_evt <= ev;
      @(posedge pclk);
      rx_frame <= '0;
      mac_wake_evt <= 1'b0;
      #1;
      chk({30'h0, rx_store, rx_wake_flag}, {30'h0, exp});
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(SWK_OFS_PMT, SWK_ZERO, 1'b0);
      rd(SWK_OFS_WSRC, SWK_ZERO, 1'b0);
      rd(12'h0FC, SWK_ZERO, 1'b1);
      $display("test reset done");
      wr(SWK_OFS_CFG1, 32'h0000_0008);
      wr(SWK_OFS_PWAKE, 32'h0800_0800);
      rd(SWK_OFS_PWAKE, 32'h0800_0800, 1'b0);
      susp(SWK_ZERO, SLP_A);
      @(posedge pclk);
      pin_in <= 12'h800;
      wait_wake();
      pin_in <= 12'h000;
      rd(SWK_OFS_WSRC, 32'h0000_0800, 1'b0);
      wr(SWK_OFS_CFG0, 32'h0000_0001);
      wr(SWK_OFS_PWAKE, 32'h0000_0001);
      susp(SWK_ZERO, SLP_A);
      wait_wake();
      wr(SWK_OFS_PWAKE, SWK_ZERO);
      rd(SWK_OFS_WSRC, 32'h0000_0801, 1'b0);
      wr(SWK_OFS_WSRC, 32'h0000_0801);
      rd(SWK_OFS_WSRC, SWK_ZERO, 1'b0);
      $display("test pin wake done");
      mac_wake_evt <= 1'b1;
      wr(SWK_OFS_PMT, 32'h0000_0002);
      rd(SWK_OFS_PMT, 32'h0000_0002, 1'b0);
      mac_wake_evt <= 1'b0;
      wr(SWK_OFS_PMT, 32'h0000_0002);
      rd(SWK_OFS_PMT, SWK_ZERO, 1'b0);
      wr(SWK_OFS_WUC1, 32'h0000_0003);
      rd(SWK_OFS_WUC1, 32'h0000_0003, 1'b0);
      susp(32'h0000_0034, SLP_D);
      send('0, 1'b1, 2'b00);
      wait_wake();
      rd(SWK_OFS_WSRC, 32'h0001_0000, 1'b0);
      wr(SWK_OFS_WSRC, 32'h0001_0000);
      wr(SWK_OFS_PMT, 32'h0000_0002);
      $display("test lan wake done");
      phy_irq <= 1'b1;
      wr(SWK_OFS_PMT, 32'h0000_0001);
      rd(SWK_OFS_PMT, 32'h0000_0001, 1'b0);
      phy_irq <= 1'b0;
      susp(32'h0000_0018, SLP_B);
      wait_wake();
      rd(SWK_OFS_WSRC, 32'h0002_0000, 1'b0);
      rd(SWK_OFS_PMT, 32'h0000_0019, 1'b0);
      wr(SWK_OFS_WSRC, 32'h0002_0000);
      wr(SWK_OFS_PMT, 32'h0000_0001);
      rd(SWK_OFS_PMT, SWK_ZERO, 1'b0);
      $display("test link wake done");
      wr(SWK_OFS_WUC1, 32'h0000_000C);
      susp(32'h0000_0030, SLP_D);
      send(5'b10100, 1'b0, 2'b00);
      send(5'b11000, 1'b0, 2'b00);
      chk({31'h0, suspended}, 32'h1);
      rd(SWK_OFS_PMT, 32'h0000_0130, 1'b0);
      send(5'b11100, 1'b0, 2'b11);
      wait_wake();
      rd(SWK_OFS_WSRC, 32'h0004_0000, 1'b0);
      send(5'b11100, 1'b0, 2'b10);
      send(5'b10100, 1'b0, 2'b00);
      wr(SWK_OFS_WSRC, 32'h0004_0000);
      $display("test good frame done");
      wr(SWK_OFS_RFC, 32'h0000_0010);
      wr(SWK_OFS_WUC1, 32'h0000_0008);
      susp(32'h0000_0034, SLP_D);
      send(5'b11000, 1'b1, 2'b11);
      wait_wake();
      rd(SWK_OFS_WSRC, 32'h0001_0000, 1'b0);
      $display("test always pass done");
      wrap_up();
   end
endmodule
